// ==== core/t2b_fall_sync.sv ====
/*
  Two-flop synchroniser with falling edge pulse for an external pin.
  Assumes the pin is asynchronous to hclk and held at least two clocks per level.
*/
`default_nettype none
module t2b_fall_sync
  import t2b_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } t2b_sync_t;
  t2b_sync_t s;
  t2b_sync_t next_s;

  // meta feeds only sync; the edge looks at sync and last
  always_comb begin
    next_s = s;
    next_s.meta = pin;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end

  // idle high, so a pin held low out of reset gives one fall pulse two clocks later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign fall = s.last & ~s.sync;
endmodule : t2b_fall_sync
`default_nettype wire

// ==== core/t2b_pkg.sv ====
/*
  Shared constants and types of the timer 2 baud rate block:
  register offsets, control field positions, reset values, prescale counts.
  Assumes one 100 MHz hclk that stands in for the oscillator clock.
*/
`default_nettype none
package t2b_pkg;
  // byte offsets on the register bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_CLKMODE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  // control register fields
  localparam int CTRL_CRS = 0;
  localparam int CTRL_CTS = 1;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_EXEN = 3;
  localparam int CTRL_TXSEL = 4;
  localparam int CTRL_RXSEL = 5;
  localparam int CTRL_EXF = 6;
  localparam int CTRL_OVF = 7;
  // interrupt status and mask fields
  localparam int EV_OVF = 0;
  localparam int EV_EXT = 1;
  localparam int EV_BAUD = 2;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic CLKMODE_RESET = 1'b0;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  // oscillator clocks per count step
  localparam logic [3:0] PRE_BAUD_6 = 4'h1;
  localparam logic [3:0] PRE_BAUD_12 = 4'h2;
  localparam logic [3:0] PRE_MC_6 = 4'h6;
  localparam logic [3:0] PRE_MC_12 = 4'hc;
  // overflow strobes per serial bit, as last value of a 4-bit divider
  localparam logic [3:0] BIT_DIV_LAST = 4'hf;
  typedef enum logic [1:0] {MODE_OFF, MODE_RELOAD, MODE_CAPTURE, MODE_BAUD} t2b_mode_t;
endpackage : t2b_pkg
`default_nettype wire

// ==== core/t2b_prescale.sv ====
/*
  Count-step divider: one-cycle tick every limit clocks while run is high.
  Assumes limit is at least one; a limit change applies to the period in progress.
*/
`default_nettype none
module t2b_prescale
  import t2b_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } t2b_pre_t;
  t2b_pre_t s;
  t2b_pre_t next_s;

  // restart from zero whenever stopped, so the first step is a full period
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = '0;
    end else if (s.cnt >= W'(limit - 1'b1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = W'(s.cnt + 1'b1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : t2b_prescale
`default_nettype wire

// ==== core/t2b_timer.sv ====
/*
  Timer 2 with baud rate generation, AHB-Lite register slave and interrupt.
  Assumes a single AHB-Lite master, word transfers, and the serial port
  dividing nothing itself: bit ticks are produced here.
*/
`default_nettype none
module t2b_timer
  import t2b_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic count_pin,
  input wire logic trigger_pin,
  input wire logic timer1_overflow,
  output logic tx_baud_strobe,
  output logic rx_baud_strobe,
  output logic tx_bit_tick,
  output logic rx_bit_tick,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    logic six_clk;
    logic [2:0] status;
    logic [2:0] mask;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic t2_ovf;
    logic [3:0] tx_div;
    logic [3:0] rx_div;
    logic tx_bit;
    logic rx_bit;
  } t2b_state_t;
  t2b_state_t s;
  t2b_state_t next_s;

  logic cnt_fall;
  logic trig_fall;
  logic pre_tick;
  logic run;
  logic baud;
  logic cts;
  logic run_pre;
  logic inc;
  logic ovf_evt;
  logic ext_evt;
  logic acc;
  logic [3:0] pre_limit;
  logic [31:0] rd_val;
  logic [2:0] ev;
  t2b_mode_t mode;

  // both pins come from outside the clock domain
  t2b_fall_sync u_cnt_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(count_pin),
    .fall(cnt_fall)
  );
  t2b_fall_sync u_trig_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(trigger_pin),
    .fall(trig_fall)
  );

  // mode decode
  assign run = s.ctrl[CTRL_RUN];
  assign baud = s.ctrl[CTRL_TXSEL] | s.ctrl[CTRL_RXSEL];
  assign cts = s.ctrl[CTRL_CTS];
  always_comb begin
    if (!run) begin
      mode = MODE_OFF;
    end else if (baud) begin
      mode = MODE_BAUD;
    end else if (s.ctrl[CTRL_CRS]) begin
      mode = MODE_CAPTURE;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  // baud steps at osc or osc/2; otherwise one step per machine cycle
  always_comb begin
    if (baud) begin
      pre_limit = s.six_clk ? PRE_BAUD_6 : PRE_BAUD_12;
    end else begin
      pre_limit = s.six_clk ? PRE_MC_6 : PRE_MC_12;
    end
  end
  assign run_pre = run & ~cts;
  t2b_prescale #(
    .W(4)
  ) u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run_pre),
    .limit(pre_limit),
    .tick(pre_tick)
  );

  // count step from prescaler or from the count pin
  assign inc = run & (cts ? cnt_fall : pre_tick);
  assign ovf_evt = inc & (s.count == COUNT_TOP);
  assign ext_evt = s.ctrl[CTRL_EXEN] & trig_fall;
  assign acc = hsel & hready & htrans[1];

  // overflow strobe routing to the serial port
  assign tx_baud_strobe = s.ctrl[CTRL_TXSEL] ? s.t2_ovf : timer1_overflow;
  assign rx_baud_strobe = s.ctrl[CTRL_RXSEL] ? s.t2_ovf : timer1_overflow;

  // read mux; unmapped offsets read as zero
  always_comb begin
    unique case (s.addr)
      ADDR_CTRL: rd_val = {24'h000000, s.ctrl};
      ADDR_COUNT: rd_val = {16'h0000, s.count};
      ADDR_RELOAD: rd_val = {16'h0000, s.reload};
      ADDR_CLKMODE: rd_val = {31'h00000000, s.six_clk};
      ADDR_STATUS: rd_val = {29'h00000000, s.status};
      ADDR_MASK: rd_val = {29'h00000000, s.mask};
      default: rd_val = 32'h00000000;
    endcase
  end

  // interrupt events of this cycle
  always_comb begin
    ev = 3'h0;
    ev[EV_OVF] = ovf_evt & (mode != MODE_BAUD);
    ev[EV_EXT] = ext_evt;
    ev[EV_BAUD] = ovf_evt & (mode == MODE_BAUD);
  end

  // next state: bus, software writes, then hardware, set wins over clear
  always_comb begin
    next_s = s;
    next_s.wr_pend = acc & hwrite;
    next_s.rd_pend = acc & ~hwrite;
    if (acc) begin
      next_s.addr = haddr[7:0];
    end
    // rdata settles during the one read wait state
    if (s.rd_pend) begin
      next_s.rdata = rd_val;
    end
    if (s.wr_pend) begin
      unique case (s.addr)
        ADDR_CTRL: next_s.ctrl = hwdata[7:0];
        ADDR_RELOAD: next_s.reload = hwdata[15:0];
        ADDR_CLKMODE: next_s.six_clk = hwdata[0];
        ADDR_MASK: next_s.mask = hwdata[2:0];
        default: next_s.ctrl = next_s.ctrl;
      endcase
    end
    if (s.wr_pend && s.addr == ADDR_STATUS) begin
      next_s.status = s.status & ~hwdata[2:0];
    end
    next_s.status = next_s.status | ev;
    // counting
    if (inc) begin
      next_s.count = 16'(s.count + 1'b1);
    end
    next_s.t2_ovf = ovf_evt & (mode == MODE_BAUD);
    if (ovf_evt) begin
      if (mode == MODE_BAUD) begin
        next_s.count = s.reload;
      end else begin
        next_s.ctrl[CTRL_OVF] = 1'b1;
        if (mode == MODE_RELOAD) begin
          next_s.count = s.reload;
        end
      end
    end
    // trigger edge: flag always, reload or capture only outside baud
    if (ext_evt) begin
      next_s.ctrl[CTRL_EXF] = 1'b1;
      if (mode == MODE_RELOAD) begin
        next_s.count = s.reload;
      end else if (mode == MODE_CAPTURE) begin
        next_s.reload = s.count;
      end
    end
    // software count write wins; it is off-limits while baud runs
    if (s.wr_pend && s.addr == ADDR_COUNT) begin
      next_s.count = hwdata[15:0];
    end
    // divide overflow strobes by 16 into serial bit ticks
    next_s.tx_bit = 1'b0;
    next_s.rx_bit = 1'b0;
    if (tx_baud_strobe) begin
      next_s.tx_div = 4'(s.tx_div + 1'b1);
      next_s.tx_bit = (s.tx_div == BIT_DIV_LAST);
    end
    if (rx_baud_strobe) begin
      next_s.rx_div = 4'(s.rx_div + 1'b1);
      next_s.rx_bit = (s.rx_div == BIT_DIV_LAST);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.count <= COUNT_RESET;
      s.reload <= RELOAD_RESET;
      s.six_clk <= CLKMODE_RESET;
      s.status <= STATUS_RESET;
      s.mask <= MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  // reads take one wait state so a write just before is seen
  assign hreadyout = ~s.rd_pend;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign tx_bit_tick = s.tx_bit;
  assign rx_bit_tick = s.rx_bit;
  assign irq = |(s.status & s.mask);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_off_hold: assert property (
    (!run && !(s.wr_pend && s.addr == ADDR_COUNT)) |=> $stable(s.count))
    else $error("counter moved while stopped");
  a_tx_route: assert property (
    (ovf_evt && mode == MODE_BAUD && s.ctrl[CTRL_TXSEL] && !(s.wr_pend && s.addr == ADDR_CTRL)) |=> tx_baud_strobe)
    else $error("tx strobe missing after baud overflow");
  a_rx_route: assert property (
    (!s.ctrl[CTRL_RXSEL] && !timer1_overflow) |-> !rx_baud_strobe)
    else $error("rx strobe without timer 1 overflow");
  a_baud_reload: assert property (
    (ovf_evt && mode == MODE_BAUD && !s.wr_pend) |=> s.count == $past(s.reload))
    else $error("baud overflow did not reload");
  a_bit_div: assert property (
    (tx_baud_strobe && s.tx_div == BIT_DIV_LAST) |=> tx_bit_tick ##1 !tx_bit_tick)
    else $error("tx bit tick not one in sixteen");
  a_baud_six: assert property (
    (run_pre && baud && s.six_clk) |=> pre_tick)
    else $error("6-clock baud step missing");
  a_baud_twelve: assert property (
    (pre_tick && run_pre && baud && !s.six_clk) |=> !pre_tick)
    else $error("12-clock baud step too fast");
  a_mc_spacing: assert property (
    (pre_tick && run_pre && !baud) ##1 (run_pre && !baud)[*5] |-> !pre_tick)
    else $error("machine cycle step too fast");
  a_baud_noflag: assert property (
    (ovf_evt && mode == MODE_BAUD && !s.wr_pend) |=> !$rose(s.ctrl[CTRL_OVF]) && !$rose(s.status[EV_OVF]))
    else $error("baud overflow set the flag");
  a_ext_noreload: assert property (
    (ext_evt && mode == MODE_BAUD && !ovf_evt && !s.wr_pend) |=>
      (16'(s.count - $past(s.count)) <= 16'h0001) && s.ctrl[CTRL_EXF])
    else $error("baud trigger edge misbehaved");
  a_ovf_sticky: assert property (
    (s.ctrl[CTRL_OVF] && !s.wr_pend) |=> s.ctrl[CTRL_OVF])
    else $error("overflow flag lost");
  c_baud_ovf: cover property (ovf_evt && mode == MODE_BAUD);
  c_capture: cover property (ext_evt && mode == MODE_CAPTURE);
  c_bit_tick: cover property (tx_bit_tick && rx_bit_tick);
  c_irq: cover property ($rose(irq));
endmodule : t2b_timer
`default_nettype wire

// ==== verification/t2b_serial_model.sv ====
/*
  serial port stand-in: counts baud strobes and bit ticks per route
  and makes timer 1 overflow pulses.
  assumes the timer's hclk and hresetn; counters clear on a one-cycle clear.
*/
`default_nettype none
module t2b_serial_model #(
  parameter int T1_DIV = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic tx_baud_strobe,
  input wire logic rx_baud_strobe,
  input wire logic tx_bit_tick,
  input wire logic rx_bit_tick,
  output logic timer1_overflow,
  output logic [15:0] tx_strobes,
  output logic [15:0] rx_strobes,
  output logic [15:0] tx_ticks,
  output logic [15:0] rx_ticks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] t1_cnt;
  // timer 1 stand-in: periodic, so any window of whole periods counts exactly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_cnt <= 8'h00;
      timer1_overflow <= 1'b0;
    end else begin
      t1_cnt <= (t1_cnt == 8'(T1_DIV - 1)) ? 8'h00 : t1_cnt + 8'h01;
      timer1_overflow <= (t1_cnt == 8'(T1_DIV - 1));
    end
  end
  // rate counters, read by the bench after a measuring window
  always_ff @(posedge hclk) begin
    if (clear) begin
      tx_strobes <= 16'h0000;
      rx_strobes <= 16'h0000;
      tx_ticks <= 16'h0000;
      rx_ticks <= 16'h0000;
    end else begin
      tx_strobes <= tx_strobes + 16'(tx_baud_strobe);
      rx_strobes <= rx_strobes + 16'(rx_baud_strobe);
      tx_ticks <= tx_ticks + 16'(tx_bit_tick);
      rx_ticks <= rx_ticks + 16'(rx_bit_tick);
    end
  end
endmodule : t2b_serial_model
`default_nettype wire

// ==== verification/t2b_timer_test.sv ====
/*
  self-checking bench for the timer 2 baud block over AHB-Lite.
  assumes one slave, so hready is fed back from hreadyout.
*/
`default_nettype none
module t2b_timer_test
  import t2b_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, count_pin, trigger_pin, clear;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans, pin_div;
  logic [2:0] hsize;
  logic hreadyout, hresp, irq, t1_ovf, tx_s, rx_s, tx_t, rx_t;
  logic [31:0] hrdata;
  logic [15:0] txs, rxs, txt, rxt;
  int err_total, n_tests, cycles;
  logic [7:0] ctl [5] = '{8'h34, 8'h34, 8'h14, 8'h24, 8'h36};
  logic clk6 [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0] rel [5] = '{16'hffff, 16'hfffe, 16'hfffc, 16'hffff, 16'hffff};
  logic [15:0] e_tx [5] = '{16'h0100, 16'h0040, 16'h0040, 16'h0020, 16'h0020};
  logic [15:0] e_rx [5] = '{16'h0100, 16'h0040, 16'h0020, 16'h0080, 16'h0020};

  t2b_timer t2b_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .timer1_overflow(t1_ovf), .tx_baud_strobe(tx_s), .rx_baud_strobe(rx_s), .tx_bit_tick(tx_t),
    .rx_bit_tick(rx_t), .irq(irq));
  t2b_serial_model t2b_serial_model_inst (.hclk(hclk), .hresetn(hresetn), .clear(clear),
    .tx_baud_strobe(tx_s), .rx_baud_strobe(rx_s), .tx_bit_tick(tx_t), .rx_bit_tick(rx_t),
    .timer1_overflow(t1_ovf), .tx_strobes(txs), .rx_strobes(rxs), .tx_ticks(txt), .rx_ticks(rxt));

  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // count pin falls every 8 clocks, slow enough for the synchroniser
  always @(posedge hclk) begin
    pin_div <= pin_div + 2'h1;
    if (pin_div == 2'h3) count_pin <= ~count_pin;
  end
  // hang guard, well above the roughly 2000 cycles the run needs
  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one single transfer; holds each phase until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rdchk

  // clear the partner's counters, then count over 256 clocks
  task automatic measure();
    clear <= 1'b1;
    @(posedge hclk);
    clear <= 1'b0;
    repeat (256) @(posedge hclk);
    #1;
  endtask : measure

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    count_pin = 1'b1;
    trigger_pin = 1'b1;
    clear = 1'b0;
    pin_div = 2'h0;
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, 0x18 being unmapped
    for (int i = 0; i < 7; i++) rdchk(8'(4 * i), 32'h0, "reset value");
    // baud routes and rates, timer and counter clocking
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CLKMODE, {31'h0, clk6[i]});
      wr(ADDR_RELOAD, {16'h0, rel[i]});
      wr(ADDR_COUNT, {16'h0, rel[i]});
      wr(ADDR_CTRL, {24'h0, ctl[i]});
      repeat (40) @(posedge hclk);
      measure();
      chk("tx strobes", {16'h0, e_tx[i]}, {16'h0, txs});
      chk("rx strobes", {16'h0, e_rx[i]}, {16'h0, rxs});
      chk("tx ticks", {20'h0, e_tx[i][15:4]}, {16'h0, txt});
      chk("rx ticks", {20'h0, e_rx[i][15:4]}, {16'h0, rxt});
      rdchk(ADDR_CTRL, {24'h0, ctl[i]}, "baud ctrl flags");
    end
    rdchk(ADDR_STATUS, 32'h4, "status after baud");
    // trigger edge in baud mode raises the flag and the interrupt
    wr(ADDR_MASK, 32'h2);
    wr(ADDR_STATUS, 32'h7);
    // slow baud count far from the reload value, so a reload would show
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CLKMODE, 32'h0);
    wr(ADDR_RELOAD, 32'h8000);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, 32'h3c);
    trigger_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("irq on trigger", 32'h1, {31'h0, irq});
    rdchk(ADDR_CTRL, 32'h7c, "external flag");
    wr(ADDR_STATUS, 32'h2);
    repeat (2) @(posedge hclk);
    chk("irq after clear", 32'h0, {31'h0, irq});
    wr(ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_COUNT, 32'h0, q);
    chk("no baud trigger reload", 32'h1, 32'(q < 32'h100));
    trigger_pin <= 1'b1;
    // auto-reload mode: machine cycle rate, then trigger reload
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CLKMODE, 32'h0);
    wr(ADDR_RELOAD, 32'h1234);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_CTRL, 32'h0c);
    repeat (120) @(posedge hclk);
    wr(ADDR_CTRL, 32'h08);
    bus(1'b0, ADDR_COUNT, 32'h0, q);
    chk("machine cycle steps", 32'h1, 32'(q >= 32'd9 && q <= 32'd11));
    wr(ADDR_CTRL, 32'h0c);
    trigger_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    rdchk(ADDR_CTRL, 32'h4c, "trigger flag");
    wr(ADDR_CTRL, 32'h08);
    bus(1'b0, ADDR_COUNT, 32'h0, q);
    chk("trigger reload", 32'h1, 32'(q >= 32'h1234 && q <= 32'h1235));
    // overflow flag is sticky until written away
    wr(ADDR_COUNT, 32'hfff0);
    wr(ADDR_CLKMODE, 32'h1);
    wr(ADDR_CTRL, 32'h04);
    repeat (120) @(posedge hclk);
    rdchk(ADDR_CTRL, 32'h84, "overflow flag");
    repeat (60) @(posedge hclk);
    rdchk(ADDR_CTRL, 32'h84, "overflow flag held");
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk("overflow status", 32'h1, {31'h0, q[EV_OVF]});
    wr(ADDR_CTRL, 32'h0);
    rdchk(ADDR_CTRL, 32'h0, "flag cleared");
    // capture mode: trigger edge copies the count into the reload pair
    trigger_pin <= 1'b1;
    wr(ADDR_COUNT, 32'h100);
    wr(ADDR_RELOAD, 32'h0);
    wr(ADDR_CTRL, 32'h0d);
    trigger_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    wr(ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_RELOAD, 32'h0, q);
    chk("capture value", 32'h1, 32'(q >= 32'h100 && q <= 32'h102));
    conclude();
  end
endmodule : t2b_timer_test
`default_nettype wire
